/* timer_counter.sv */
// 16-bit timer/counter with timer and external trigger modes, Avalon-MM registers
// Function
// - Mode field: only mode 00 (timer) runs the counter
// - Timer mode: match raises irq, clears, continues
// - Auto-capture copies counter into capture register
// - Select codes give documented source periods
// - Selected pin edge starts trigger counting
// - Trigger mode match clears, halts, raises irq
// - Stop bit: opposite edge halts, no irq
// - Halted counter restarts on next trigger
// - Stop bit clear: opposite edge ignored
// - Stop bit clear: retrigger while running ignored
// - Filter rejects short pulses, keeps long
// - Low-frequency modes bypass the filter
// - Compare loads on tick after upper byte
// - Stop power mode forces start field 00
// - Clock select picks prescaler tap or pin
//
// Chosen here: the register offsets and the Avalon-MM register port.
module timer_counter #(
  parameter int unsigned FS_PERIOD = timer_pkg::FS_PERIOD_CYC,
  parameter int unsigned CNT_WIDTH = 16
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        trigger_input_pin,
  input  wire logic        stop_mode_enter,
  output logic             timer_irq
);
  initial begin
    if (CNT_WIDTH != 16)
      $error("timer_counter: CNT_WIDTH must be 16");
    if (FS_PERIOD < 2 || FS_PERIOD > 65535)
      $error("timer_counter: FS_PERIOD out of range");
  end

  localparam logic [15:0] FS_LAST = 16'(FS_PERIOD - 1);

  typedef enum logic [1:0] {ST_IDLE, ST_COUNT, ST_HALT} run_state_t;

  // Registers
  timer_pkg::control_t   control_reg_q;
  timer_pkg::power_t     power_reg_q;
  logic [CNT_WIDTH-1:0]  compare_reg_a_q;
  logic [CNT_WIDTH-1:0]  compare_stage_q;
  logic                  compare_pend_q;
  logic [CNT_WIDTH-1:0]  capture_reg_b_q;
  logic [CNT_WIDTH-1:0]  count_q;
  run_state_t            state_q;
  logic [10:0]           pre_q;
  logic [15:0]           fs_cnt_q;
  logic [2:0]            fs_div_q;
  logic                  pin_prev_q;
  logic                  irq_q;
  logic [31:0]           rdata_q;
  logic                  wait_q;

  // Bus request bundle
  timer_pkg::bus_req_t req;
  assign req = '{address: avs_address, read: avs_read, write: avs_write,
                 writedata: avs_writedata, byteenable: avs_byteenable};

  // Filtered trigger pin
  logic pin_level;
  trigger_filter #(
    .STABLE_CYCLES(timer_pkg::FILT_STABLE_CYC)
  ) u_filter (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pin_async(trigger_input_pin),
    .bypass   (power_reg_q.low_freq_mode),
    .level_q  (pin_level)
  );

  // Bus access decode; a request is served in the cycle wait_q is low
  wire bus_go   = (req.read || req.write) && !wait_q;
  wire wr_go    = bus_go && req.write;
  wire sel_ctl  = (req.address == timer_pkg::OFF_CONTROL);
  wire sel_cmp  = (req.address == timer_pkg::OFF_COMPARE);
  wire sel_cap  = (req.address == timer_pkg::OFF_CAPTURE);
  wire sel_sts  = (req.address == timer_pkg::OFF_STATUS);
  wire sel_pwr  = (req.address == timer_pkg::OFF_POWER);
  wire wr_ctl   = wr_go && sel_ctl && req.byteenable[0];
  wire wr_cmp_l = wr_go && sel_cmp && req.byteenable[0];
  wire wr_cmp_h = wr_go && sel_cmp && req.byteenable[1];
  wire wr_pwr   = wr_go && sel_pwr && req.byteenable[0];

  // Read data mux, unmapped reads return zero
  wire [31:0] rd_mux =
      sel_ctl ? {24'h000000, control_reg_q} :
      sel_cmp ? {16'h0000, compare_reg_a_q} :
      sel_cap ? {16'h0000, capture_reg_b_q} :
      sel_sts ? {15'h0000, (state_q == ST_COUNT), count_q} :
      sel_pwr ? {30'h00000000, power_reg_q} :
      32'h00000000;

  // Source clock taps from the prescalers
  wire fs_tick   = (fs_cnt_q == FS_LAST);
  wire fs8_tick  = fs_tick && (&fs_div_q);
  wire tap_slow  = &pre_q[timer_pkg::DIV_SLOW_BITS-1:0];
  wire tap_mid   = &pre_q[timer_pkg::DIV_MID_BITS-1:0];
  wire tap_fast  = &pre_q[timer_pkg::DIV_FAST_BITS-1:0];
  wire use_fs    = power_reg_q.divider_option_bit || power_reg_q.low_freq_mode;
  wire pin_rise  = pin_level && !pin_prev_q;
  wire pin_fall  = !pin_level && pin_prev_q;

  // Source clock select; only selects 00 and 11 (pin) run in low-frequency modes
  logic src_tick;
  always_comb begin
    unique case (control_reg_q.source_clock_sel)
      timer_pkg::CLK_SEL_SLOW: src_tick = use_fs ? fs8_tick : tap_slow;
      timer_pkg::CLK_SEL_MID:  src_tick = !power_reg_q.low_freq_mode && tap_mid;
      timer_pkg::CLK_SEL_FAST: src_tick = !power_reg_q.low_freq_mode && tap_fast;
      timer_pkg::CLK_SEL_PIN:  src_tick = pin_rise;
    endcase
  end

  // Mode decode
  wire [1:0] start_code = control_reg_q.start_control;
  wire mode_tmr   = (control_reg_q.mode_sel == timer_pkg::MODE_TIMER);
  wire cmd_mode   = mode_tmr && (control_reg_q.start_control == timer_pkg::START_CMD);
  wire ext_mode   = mode_tmr && (control_reg_q.start_control == timer_pkg::START_RISE ||
                                 control_reg_q.start_control == timer_pkg::START_FALL);
  wire stopped    = (control_reg_q.start_control == timer_pkg::START_STOP);
  wire fall_sel   = (control_reg_q.start_control == timer_pkg::START_FALL);
  wire trig_edge  = fall_sel ? pin_fall : pin_rise;
  wire opp_edge   = fall_sel ? pin_rise : pin_fall;
  wire stop_sel   = control_reg_q.capt_or_stop;    // trigger_stop_sel in trigger mode
  wire cap_en     = control_reg_q.capt_or_stop && cmd_mode; // auto_capture_en
  wire running    = (state_q == ST_COUNT);
  wire match      = (count_q == compare_reg_a_q);
  wire tick_run   = running && src_tick;
  wire hit        = tick_run && match;
  wire abort      = running && ext_mode && stop_sel && opp_edge && !hit;

  // Next control value: stop power mode wins over a software write of the start field
  timer_pkg::control_t control_d;
  always_comb begin
    control_d = control_reg_q;
    if (wr_ctl)
      control_d = timer_pkg::control_t'(req.writedata[7:0]);
    if (stop_mode_enter)
      control_d.start_control = timer_pkg::START_STOP;
  end

  // Run state machine
  run_state_t state_d;
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (cmd_mode)
          state_d = ST_COUNT;
        else if (ext_mode && trig_edge)
          state_d = ST_COUNT;
        else if (ext_mode)
          state_d = ST_HALT;
      end
      ST_COUNT: begin
        if (ext_mode && (hit || abort))
          state_d = ST_HALT;
      end
      ST_HALT: begin
        if (ext_mode && trig_edge)
          state_d = ST_COUNT;
      end
    endcase
    if (stopped || stop_mode_enter || !(cmd_mode || ext_mode))
      state_d = ST_IDLE;
    else if (cmd_mode && state_q == ST_HALT)
      state_d = ST_COUNT;
  end

  // Counter next value; retrigger edges, and opposite edges with the stop bit clear, leave a running count alone
  logic [CNT_WIDTH-1:0] count_d;
  always_comb begin
    count_d = count_q;
    if (state_d == ST_IDLE || abort)
      count_d = timer_pkg::COUNT_RST;
    else if (state_q != ST_COUNT && state_d == ST_COUNT)
      count_d = timer_pkg::COUNT_RST;
    else if (hit)
      count_d = timer_pkg::COUNT_RST;
    else if (tick_run)
      count_d = count_q + 16'h0001;
  end

  // Bus handshake: one wait cycle, then serve
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q  <= !((req.read || req.write) && wait_q);
      rdata_q <= rd_mux;
    end
  end

  // Control and power registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      control_reg_q <= timer_pkg::control_t'(timer_pkg::CONTROL_RST);
      power_reg_q   <= '0;
    end else begin
      control_reg_q <= control_d;
      if (wr_pwr)
        power_reg_q <= timer_pkg::power_t'(req.writedata[1:0]);
    end
  end

  // Compare register: staged bytes load on the first tick after the upper byte
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      compare_reg_a_q <= timer_pkg::COMPARE_RST;
      compare_stage_q <= timer_pkg::COMPARE_RST;
      compare_pend_q  <= 1'b0;
    end else begin
      if (wr_cmp_l)
        compare_stage_q[7:0] <= req.writedata[7:0];
      if (wr_cmp_h)
        compare_stage_q[15:8] <= req.writedata[15:8];
      if (wr_cmp_h)
        compare_pend_q <= 1'b1;
      else if (compare_pend_q && src_tick)
        compare_pend_q <= 1'b0;
      if (compare_pend_q && src_tick && !wr_cmp_h)
        compare_reg_a_q <= compare_stage_q;
    end
  end

  // Counter, state, capture and interrupt pulse
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q         <= ST_IDLE;
      count_q         <= timer_pkg::COUNT_RST;
      capture_reg_b_q <= timer_pkg::COUNT_RST;
      irq_q           <= 1'b0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      if (cap_en && tick_run)
        capture_reg_b_q <= count_q;
      irq_q <= hit && (cmd_mode || ext_mode);
    end
  end

  // Prescalers and pin edge history
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pre_q      <= 11'h000;
      fs_cnt_q   <= 16'h0000;
      fs_div_q   <= 3'h0;
      pin_prev_q <= 1'b0;
    end else begin
      pre_q      <= pre_q + 11'h001;
      fs_cnt_q   <= fs_tick ? 16'h0000 : fs_cnt_q + 16'h0001;
      if (fs_tick)
        fs_div_q <= fs_div_q + 3'h1;
      pin_prev_q <= pin_level;
    end
  end

  // Outputs straight from flip-flops
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign timer_irq       = irq_q;

  wire unused_ok = &{1'b0, start_code, control_reg_q.flipflop_ctrl};
endmodule : timer_counter

/* trigger_filter.sv */
// Shared constants and types, plus the trigger pin synchroniser and noise filter
package timer_pkg;
  // Register byte offsets
  localparam logic [4:0] OFF_CONTROL  = 5'h00;
  localparam logic [4:0] OFF_COMPARE  = 5'h04;
  localparam logic [4:0] OFF_CAPTURE  = 5'h08;
  localparam logic [4:0] OFF_STATUS   = 5'h0C;
  localparam logic [4:0] OFF_POWER    = 5'h10;
  // Reset values
  localparam logic [7:0]  CONTROL_RST = 8'h00;
  localparam logic [15:0] COMPARE_RST = 16'hFFFF;
  localparam logic [15:0] COUNT_RST   = 16'h0000;
  // Field codes
  localparam logic [1:0] START_STOP    = 2'h0;
  localparam logic [1:0] START_CMD     = 2'h1;
  localparam logic [1:0] START_RISE    = 2'h2;
  localparam logic [1:0] START_FALL    = 2'h3;
  localparam logic [1:0] MODE_TIMER    = 2'h0;
  localparam logic [1:0] CLK_SEL_SLOW  = 2'h0;
  localparam logic [1:0] CLK_SEL_MID   = 2'h1;
  localparam logic [1:0] CLK_SEL_FAST  = 2'h2;
  localparam logic [1:0] CLK_SEL_PIN   = 2'h3;
  // Prescaler exponents of fc (fc is clk); FS_DIV_BITS is the exponent of fs
  localparam int unsigned DIV_SLOW_BITS = 11;
  localparam int unsigned DIV_MID_BITS  = 7;
  localparam int unsigned DIV_FAST_BITS = 3;
  localparam int unsigned FS_DIV_BITS   = 3;
  // Low-frequency clock period in clk cycles (32.768 kHz at 100 MHz)
  localparam int unsigned FS_PERIOD_CYC = 3052;
  // Noise filter bounds in fc cycles
  localparam int unsigned FILT_REJECT_CYC = 4;
  localparam int unsigned FILT_ACCEPT_CYC = 12;
  localparam int unsigned FILT_STABLE_CYC = 8;

  // Control register, bit 7 down to bit 0
  typedef struct packed {
    logic       flipflop_ctrl;
    logic       capt_or_stop;   // auto_capture_en / trigger_stop_sel
    logic [1:0] start_control;
    logic [1:0] source_clock_sel;
    logic [1:0] mode_sel;
  } control_t;

  // Power and divider control
  typedef struct packed {
    logic low_freq_mode;
    logic divider_option_bit;
  } power_t;

  // Avalon request bundle
  typedef struct packed {
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } bus_req_t;
endpackage : timer_pkg

// Two-stage synchroniser followed by a stability filter
module trigger_filter #(
  parameter int unsigned STABLE_CYCLES = timer_pkg::FILT_STABLE_CYC
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic pin_async,
  input  wire logic bypass,
  output logic      level_q
);
  initial begin
    if (STABLE_CYCLES <= timer_pkg::FILT_REJECT_CYC || STABLE_CYCLES >= timer_pkg::FILT_ACCEPT_CYC)
      $error("trigger_filter: STABLE_CYCLES out of range");
  end

  logic       sync1_q;
  logic       sync2_q;
  logic [3:0] stable_q;
  wire        same  = (sync2_q == level_q);
  wire        ripe  = (stable_q == 4'(STABLE_CYCLES - 1));

  // Synchroniser, first stage read only by second
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= pin_async;
      sync2_q <= sync1_q;
    end
  end

  // Accept a new level only after it stays put; bypassed in low-frequency modes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      level_q  <= 1'b0;
      stable_q <= 4'h0;
    end else if (bypass || same) begin
      level_q  <= sync2_q;
      stable_q <= 4'h0;
    end else if (ripe) begin
      level_q  <= sync2_q;
      stable_q <= 4'h0;
    end else begin
      stable_q <= stable_q + 4'h1;
    end
  end
endmodule : trigger_filter

/* timer_counter_asserts.sv */
// Port-level assertions for the timer/counter block
module timer_counter_asserts (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        stop_mode_enter,
  input wire logic        timer_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Bus answer timing
  chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered next cycle");
  chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_wait_idle: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 5'h10
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_rst_quiet: assert property ($fell(sys_rst) |-> avs_waitrequest && !timer_irq)
    else $error("outputs busy after reset");
  // Interrupt shape
  chk_irq_single: assert property (timer_irq |=> !timer_irq)
    else $error("irq longer than one cycle");
  chk_irq_gap: assert property (timer_irq |=> !timer_irq [*7])
    else $error("irq again too soon");
  chk_stop_quiet: assert property (stop_mode_enter ##1 stop_mode_enter |=> !timer_irq)
    else $error("irq during stop mode");
endmodule : timer_counter_asserts

bind timer_counter timer_counter_asserts i_chk (.clk, .sys_rst, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .stop_mode_enter, .timer_irq);

/* pulse_source.sv */
// Behavioural pulse source on the trigger input pin
module pulse_source (
  input wire logic clk,
  output logic     pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pin = 1'b0;
  // Park the pin at its idle level
  task automatic park(input logic lvl);
    @(posedge clk);
    pin <= lvl;
  endtask : park
  // One pulse away from idle, each level held whole cycles
  task automatic pulse(input int w);
    @(posedge clk);
    pin <= ~pin;
    repeat (w) @(posedge clk);
    pin <= ~pin;
  endtask : pulse
endmodule : pulse_source

/* test_timer_counter.sv */
// Self-checking bench for the timer/counter block
`define chk_eq(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module test_timer_counter;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FSP = 4;
  logic                clk;
  logic                sys_rst;
  logic                stop_mode_enter;
  logic                pin;
  logic                timer_irq;
  logic                wait_n;
  logic [31:0]         rdata;
  logic [31:0]         q;
  timer_pkg::bus_req_t req;
  int                  error_cnt;
  int                  tests_run;
  int                  cyc;
  int                  cmp;
  int                  c0;
  int                  t0;
  int                  irq_q[$];
  int                  per[4];
  logic [1:0]          sel[4] = '{2'h2, 2'h1, 2'h0, 2'h0};
  int                  tc[7] = '{'h28, 'h28, 'h28, 'h78, 'h78, 'h20, 'h28};
  int                  tp[7] = '{0, 0, 0, 0, 0, 2, 0};
  int                  tw[7] = '{12, 12, 4, 20, 100, 4, 12};
  int                  tg[7] = '{0, 20, 0, 0, 0, 0, 200};
  int                  te[7] = '{1, 1, 0, 0, 1, 1, 2};

  timer_counter #(.FS_PERIOD(FSP)) i_timer_counter (
    .clk               (clk),
    .sys_rst           (sys_rst),
    .avs_address       (req.address),
    .avs_read          (req.read),
    .avs_write         (req.write),
    .avs_writedata     (req.writedata),
    .avs_byteenable    (req.byteenable),
    .avs_readdata      (rdata),
    .avs_waitrequest   (wait_n),
    .trigger_input_pin (pin),
    .stop_mode_enter   (stop_mode_enter),
    .timer_irq         (timer_irq)
  );
  pulse_source i_pulse_source (.clk(clk), .pin(pin));

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cycle count, irq log and run limit
  always @(posedge clk) begin
    cyc++;
    if (timer_irq === 1'b1) irq_q.push_back(cyc);
    if (cyc == 60000) begin
      error_cnt++;
      final_report();
    end
  end

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge clk);
    req <= '{a, !w, w, d, be};
    do @(posedge clk); while (wait_n !== 1'b0);
    q = rdata;
    req <= '{a, 1'b0, 1'b0, d, be};
  endtask : bus

  // Spacing of two successive matches
  task automatic period(input int exp);
    #1 irq_q.delete();
    wait (irq_q.size() >= 2);
    `chk_eq(irq_q[1] - irq_q[0], exp)
  endtask : period

  task automatic done(input string s);
    $display("%s test done", s);
  endtask : done

  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    stop_mode_enter = 1'b0;
    req = '0;
    error_cnt = 0;
    tests_run = 0;
    cyc = 0;
    per = '{1 << timer_pkg::DIV_FAST_BITS, 1 << timer_pkg::DIV_MID_BITS,
            1 << timer_pkg::DIV_SLOW_BITS, FSP << timer_pkg::FS_DIV_BITS};
    void'($urandom(32'h5188));
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    bus(0, timer_pkg::OFF_CONTROL, 0, 4'hF);
    `chk_eq(q[7:0], timer_pkg::CONTROL_RST)
    bus(0, timer_pkg::OFF_COMPARE, 0, 4'hF);
    `chk_eq(q[15:0], timer_pkg::COMPARE_RST)
    bus(0, 5'h14, 0, 4'hF);
    `chk_eq(q, 32'h00000000)
    done("reset");
    cmp = 2 + $urandom % 4;
    bus(1, timer_pkg::OFF_COMPARE, 32'(cmp), 4'h3);
    for (int i = 0; i < 4; i++) begin
      bus(1, timer_pkg::OFF_POWER, 32'(i / 3), 4'h1);
      bus(1, timer_pkg::OFF_CONTROL, {28'h0, sel[i], 2'h0}, 4'h1);
      bus(1, timer_pkg::OFF_CONTROL, {26'h1, sel[i], 2'h0}, 4'h1);
      period((cmp + 1) * per[i]);
    end
    bus(1, timer_pkg::OFF_COMPARE, 32'(cmp + 2), 4'h1);
    period((cmp + 1) * per[3]);
    bus(1, timer_pkg::OFF_COMPARE, 32'h0, 4'h2);
    period((cmp + 3) * per[3]);
    done("period");
    bus(1, timer_pkg::OFF_CONTROL, 32'h50, 4'h1);
    repeat (2 * per[3]) @(posedge clk);
    bus(0, timer_pkg::OFF_CAPTURE, 0, 4'hF);
    c0 = int'(q[15:0]);
    // Second sample exactly one source period after the first
    repeat (per[3] - 3) @(posedge clk);
    bus(0, timer_pkg::OFF_CAPTURE, 0, 4'hF);
    `chk_eq(q[15:0], 16'((c0 + 1) % (cmp + 3)))
    bus(0, timer_pkg::OFF_STATUS, 0, 4'hF);
    `chk_eq(q[16], 1'b1)
    bus(1, timer_pkg::OFF_COMPARE, 32'h5, 4'h3);
    done("capture");
    stop_mode_enter <= 1'b1;
    repeat (2) @(posedge clk);
    stop_mode_enter <= 1'b0;
    bus(0, timer_pkg::OFF_CONTROL, 0, 4'hF);
    `chk_eq(q[5:4], timer_pkg::START_STOP)
    #1 irq_q.delete();
    repeat (300) @(posedge clk);
    `chk_eq(irq_q.size(), 0)
    done("stop");
    for (int i = 0; i < 7; i++) begin
      bus(1, timer_pkg::OFF_CONTROL, 32'(tc[i] & 'hCF), 4'h1);
      bus(1, timer_pkg::OFF_POWER, 32'(tp[i]), 4'h1);
      i_pulse_source.park(tc[i][4]);
      repeat (20) @(posedge clk);
      bus(1, timer_pkg::OFF_CONTROL, 32'(tc[i]), 4'h1);
      #1 irq_q.delete();
      t0 = cyc;
      i_pulse_source.pulse(tw[i]);
      if (tg[i] > 0) begin
        repeat (tg[i]) @(posedge clk);
        i_pulse_source.pulse(12);
      end
      repeat (400) @(posedge clk);
      `chk_eq(irq_q.size(), te[i])
      if (i == 1) `chk_eq(irq_q[0] - t0 <= 64, 1'b1)
    end
    done("trigger");
    final_report();
  end
endmodule : test_timer_counter
